// [rtl/nsap_access_port.sv]
// Purpose: software access port to an external serial non-volatile memory
// Assumes: register port reads answer one cycle after the strobe
// Notes: direct bit access and the word read engine share the pins
module nsap_access_port #(
    parameter int UPDATE_CYCLES = nsap_pkg::NSAP_UPDATE_CYCLES,
    parameter int SK_HALF = nsap_pkg::NSAP_SK_HALF
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // autoload and strap
    input wire logic autoload_valid_in,
    input wire nsap_pkg::nsap_autoload_t autoload_in,
    input wire logic flash_strap_in,
    // flash control
    input wire logic flash_write_cycle_in,
    output logic flash_write_ok_out,
    output logic flash_erase_ok_out,
    output logic auto_update_req_out,
    // memory pins
    output logic nvm_sck_out,
    output logic nvm_cs_out,
    output logic nvm_di_out,
    input wire logic nvm_do_in
);
    import nsap_pkg::*;

    logic nvm_serial_clock_bit_q;
    logic nvm_select_bit_q;
    logic nvm_data_in_bit_q;
    logic nvm_serial_out_bit_q;
    logic [1:0] flash_write_permit_q;
    logic nvm_access_req_q;
    logic nvm_access_grant_q;
    logic auto_flash_update_en_q;
    logic strap_taken_q;
    logic is_flash_q;
    logic loaded_q;
    nsap_autoload_t autoload_q;
    logic nvm_present_flag;
    logic upper_sector_valid;
    nsap_word_read_t word_read_q;
    logic start_ok;
    logic wr_ctrl;
    logic wr_word;
    logic fetch_busy;
    logic fetch_done;
    logic [15:0] fetch_data;
    logic fetch_sck;
    logic fetch_cs;
    logic fetch_di;
    logic update_req;
    logic [31:0] ctrl_image;

    assign wr_ctrl = reg_wr_in && (reg_addr_in == NSAP_CTRL_OFS);
    assign wr_word = reg_wr_in && (reg_addr_in == NSAP_WORD_READ_OFS);

    // ==================== direct access control bits
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            nvm_serial_clock_bit_q <= 1'b0;
            nvm_select_bit_q <= 1'b0;
            nvm_data_in_bit_q <= 1'b0;
            flash_write_permit_q <= NSAP_PERMIT_RST;
            nvm_access_req_q <= 1'b0;
            auto_flash_update_en_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            nvm_serial_clock_bit_q <= reg_wdata_in[NSAP_SK_BIT];
            nvm_select_bit_q <= reg_wdata_in[NSAP_CS_BIT];
            nvm_data_in_bit_q <= reg_wdata_in[NSAP_DI_BIT];
            // the forbidden permit code is dropped
            if (reg_wdata_in[NSAP_PERMIT_LSB+:2] != NSAP_PERMIT_BAD)
                flash_write_permit_q <= reg_wdata_in[NSAP_PERMIT_LSB+:2];
            nvm_access_req_q <= reg_wdata_in[NSAP_REQ_BIT];
            auto_flash_update_en_q <= reg_wdata_in[NSAP_AUPD_BIT];
        end
    end

    // ==================== memory data output sample
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            nvm_serial_out_bit_q <= 1'b0;
        else
            nvm_serial_out_bit_q <= nvm_do_in;
    end

    // ==================== access grant
    // grant waits for a running fetch to release the pins
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            nvm_access_grant_q <= 1'b0;
        else if (!nvm_access_req_q)
            nvm_access_grant_q <= 1'b0;
        else if (!fetch_busy && !start_ok)
            nvm_access_grant_q <= 1'b1;
    end

    // ==================== strap and autoload results
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            strap_taken_q <= 1'b0;
            is_flash_q <= 1'b0;
        end
        else if (!strap_taken_q)
        begin
            strap_taken_q <= 1'b1;
            is_flash_q <= flash_strap_in;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            loaded_q <= 1'b0;
            autoload_q <= '0;
        end
        else if (autoload_valid_in)
        begin
            loaded_q <= 1'b1;
            autoload_q <= autoload_in;
        end
    end

    assign nvm_present_flag = loaded_q && autoload_q.sig_ok;
    assign upper_sector_valid = nvm_present_flag && is_flash_q && autoload_q.sector_one;

    // ==================== word read register
    assign start_ok = wr_word && reg_wdata_in[NSAP_START_BIT] && !fetch_busy && !nvm_access_grant_q;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            word_read_q.start <= 1'b0;
            word_read_q.done <= NSAP_DONE_RST;
            word_read_q.addr <= '0;
            word_read_q.data <= 16'h0000;
        end
        else
        begin
            word_read_q.start <= 1'b0;
            if (start_ok)
            begin
                word_read_q.start <= 1'b1;
                word_read_q.done <= 1'b0;
                word_read_q.addr <= reg_wdata_in[NSAP_ADDR_LSB+:NSAP_ADDR_W];
            end
            else if (fetch_done)
                word_read_q.done <= 1'b1;
            else if (wr_word && !fetch_busy && word_read_q.done)
                word_read_q.addr <= reg_wdata_in[NSAP_ADDR_LSB+:NSAP_ADDR_W];
            // completed word kept even when a new start lands in the same cycle
            if (fetch_done)
                word_read_q.data <= fetch_data;
        end
    end

    nsap_word_fetch #(
        .ADDR_BITS(NSAP_ADDR_BITS),
        .SK_HALF(SK_HALF)
    ) u_fetch (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .start_in(start_ok),
        .addr_in(reg_wdata_in[NSAP_ADDR_LSB+:NSAP_ADDR_W]),
        .busy_out(fetch_busy),
        .done_out(fetch_done),
        .data_out(fetch_data),
        .sck_out(fetch_sck),
        .cs_out(fetch_cs),
        .di_out(fetch_di),
        .do_in(nvm_do_in)
    );

    // ==================== autonomous flash update
    nsap_update_timer #(
        .UPDATE_CYCLES(UPDATE_CYCLES)
    ) u_timer (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .en_in(auto_flash_update_en_q && is_flash_q),
        .write_cycle_in(flash_write_cycle_in),
        .update_req_out(update_req)
    );

    // ==================== pin and flag outputs
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            nvm_sck_out <= 1'b0;
            nvm_cs_out <= 1'b0;
            nvm_di_out <= 1'b0;
            flash_write_ok_out <= 1'b0;
            flash_erase_ok_out <= 1'b0;
            auto_update_req_out <= 1'b0;
        end
        else
        begin
            if (nvm_access_grant_q)
            begin
                // software toggles clock with select held high
                nvm_sck_out <= nvm_serial_clock_bit_q;
                nvm_cs_out <= nvm_select_bit_q;
                nvm_di_out <= nvm_data_in_bit_q;
            end
            else
            begin
                nvm_sck_out <= fetch_sck;
                nvm_cs_out <= fetch_cs;
                nvm_di_out <= fetch_di;
            end
            flash_write_ok_out <= (flash_write_permit_q == NSAP_PERMIT_WRITE);
            flash_erase_ok_out <= (flash_write_permit_q == NSAP_PERMIT_ERASE);
            auto_update_req_out <= update_req;
        end
    end

    // ==================== register read
    always_comb
    begin
        ctrl_image = 32'h0000_0000;
        ctrl_image[NSAP_SK_BIT] = nvm_serial_clock_bit_q;
        ctrl_image[NSAP_CS_BIT] = nvm_select_bit_q;
        ctrl_image[NSAP_DI_BIT] = nvm_data_in_bit_q;
        ctrl_image[NSAP_DO_BIT] = nvm_serial_out_bit_q;
        ctrl_image[NSAP_PERMIT_LSB+:2] = flash_write_permit_q;
        ctrl_image[NSAP_REQ_BIT] = nvm_access_req_q;
        ctrl_image[NSAP_GNT_BIT] = nvm_access_grant_q;
        ctrl_image[NSAP_PRES_BIT] = nvm_present_flag;
        ctrl_image[NSAP_AUPD_BIT] = auto_flash_update_en_q;
        ctrl_image[NSAP_SEC1_BIT] = upper_sector_valid;
        ctrl_image[NSAP_KIND_BIT] = autoload_q.kind;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            reg_rdata_out <= 32'h0000_0000;
        else if (reg_rd_in && reg_addr_in == NSAP_CTRL_OFS)
            reg_rdata_out <= ctrl_image;
        else if (reg_rd_in && reg_addr_in == NSAP_WORD_READ_OFS)
            reg_rdata_out <= word_read_q;
        else
            reg_rdata_out <= 32'h0000_0000;
    end

endmodule // nsap_access_port

// [rtl/nsap_pkg.sv]
// Purpose: shared constants and types of the nvm software access port
// Assumes: 50 MHz ref_clk_in, 32-bit register port
// Notes: serial memory is read with a single-byte read opcode
package nsap_pkg;

    // ==================== register map
    localparam logic [7:0] NSAP_CTRL_OFS = 8'h10;
    localparam logic [7:0] NSAP_WORD_READ_OFS = 8'h14;

    // ==================== control register fields
    localparam int NSAP_SK_BIT = 0;
    localparam int NSAP_CS_BIT = 1;
    localparam int NSAP_DI_BIT = 2;
    localparam int NSAP_DO_BIT = 3;
    localparam int NSAP_PERMIT_LSB = 4;
    localparam int NSAP_REQ_BIT = 6;
    localparam int NSAP_GNT_BIT = 7;
    localparam int NSAP_PRES_BIT = 8;
    localparam int NSAP_AUPD_BIT = 20;
    localparam int NSAP_SEC1_BIT = 22;
    localparam int NSAP_KIND_BIT = 23;
    localparam logic [1:0] NSAP_PERMIT_RST = 2'h1;
    localparam logic [1:0] NSAP_PERMIT_ERASE = 2'h0;
    localparam logic [1:0] NSAP_PERMIT_WRITE = 2'h2;
    localparam logic [1:0] NSAP_PERMIT_BAD = 2'h3;

    // ==================== word read register fields
    localparam int NSAP_START_BIT = 0;
    localparam int NSAP_DONE_BIT = 1;
    localparam int NSAP_ADDR_LSB = 2;
    localparam int NSAP_ADDR_W = 14;
    localparam int NSAP_DATA_LSB = 16;
    localparam int NSAP_DATA_W = 16;
    localparam logic NSAP_DONE_RST = 1'b1;

    // ==================== serial read engine
    localparam logic [7:0] NSAP_READ_OP = 8'h03;
    localparam int NSAP_ADDR_BITS = 16;
    localparam int NSAP_SK_HALF = 4;

    // ==================== timing
    localparam int NSAP_CLK_MHZ = 50;
    localparam int NSAP_UPDATE_TIME_US = 1000;
    localparam int NSAP_UPDATE_CYCLES = NSAP_UPDATE_TIME_US * NSAP_CLK_MHZ;

    typedef enum {NSAP_FS_IDLE, NSAP_FS_LOW, NSAP_FS_HIGH} nsap_fetch_st_t;

    // word read register image
    typedef struct packed {
        logic [15:0] data;
        logic [13:0] addr;
        logic done;
        logic start;
    } nsap_word_read_t;

    // result of the hardware autoload
    typedef struct packed {
        logic sig_ok;
        logic sector_one;
        logic kind;
    } nsap_autoload_t;

endpackage

// [rtl/nsap_word_fetch.sv]
// Purpose: fetches one 16-bit word from the serial memory
// Assumes: opcode, byte address, then two data bytes, low byte first
// Notes: data sampled at end of each clock-high half
module nsap_word_fetch #(
    parameter int ADDR_BITS = nsap_pkg::NSAP_ADDR_BITS,
    parameter int SK_HALF = nsap_pkg::NSAP_SK_HALF
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // request and answer
    input wire logic start_in,
    input wire logic [nsap_pkg::NSAP_ADDR_W-1:0] addr_in,
    output logic busy_out,
    output logic done_out,
    output logic [15:0] data_out,
    // serial lines
    output logic sck_out,
    output logic cs_out,
    output logic di_out,
    input wire logic do_in
);
    import nsap_pkg::*;

    localparam int SR_W = 8 + ADDR_BITS;
    localparam int TOTAL = SR_W + 16;

    nsap_fetch_st_t st_q;
    logic [7:0] div_q;
    logic [7:0] bit_q;
    logic [SR_W-1:0] sr_q;
    logic [15:0] rx_q;

    // ==================== sequencer
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            st_q <= NSAP_FS_IDLE;
            div_q <= 8'h00;
            bit_q <= 8'h00;
            sr_q <= '0;
            rx_q <= 16'h0000;
            done_out <= 1'b0;
            data_out <= 16'h0000;
        end
        else
        begin
            done_out <= 1'b0;
            unique case (st_q)
                NSAP_FS_IDLE:
                begin
                    if (start_in)
                    begin
                        sr_q <= {NSAP_READ_OP, ADDR_BITS'({addr_in, 1'b0})};
                        div_q <= 8'h00;
                        bit_q <= 8'h00;
                        st_q <= NSAP_FS_LOW;
                    end
                end
                NSAP_FS_LOW:
                begin
                    if (div_q == 8'(SK_HALF - 1))
                    begin
                        div_q <= 8'h00;
                        st_q <= NSAP_FS_HIGH;
                    end
                    else
                        div_q <= div_q + 8'h01;
                end
                NSAP_FS_HIGH:
                begin
                    if (div_q == 8'(SK_HALF - 1))
                    begin
                        div_q <= 8'h00;
                        rx_q <= {rx_q[14:0], do_in};
                        sr_q <= {sr_q[SR_W-2:0], 1'b0};
                        bit_q <= bit_q + 8'h01;
                        if (bit_q == 8'(TOTAL - 1))
                        begin
                            st_q <= NSAP_FS_IDLE;
                            done_out <= 1'b1;
                            data_out <= {rx_q[6:0], do_in, rx_q[14:7]};
                        end
                        else
                            st_q <= NSAP_FS_LOW;
                    end
                    else
                        div_q <= div_q + 8'h01;
                end
            endcase
        end
    end

    assign busy_out = (st_q != NSAP_FS_IDLE);
    assign cs_out = busy_out;
    assign sck_out = (st_q == NSAP_FS_HIGH);
    assign di_out = sr_q[SR_W-1];

endmodule // nsap_word_fetch

// [rtl/nsap_update_timer.sv]
// Purpose: schedules autonomous flash updates
// Assumes: write_cycle_in is a one-cycle pulse per flash write cycle
// Notes: each write cycle restarts the delay
module nsap_update_timer #(
    parameter int UPDATE_CYCLES = nsap_pkg::NSAP_UPDATE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // control
    input wire logic en_in,
    input wire logic write_cycle_in,
    // result
    output logic update_req_out
);
    import nsap_pkg::*;

    logic pending_q;
    logic [31:0] cnt_q;

    // ==================== delay after last write
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in || !en_in)
        begin
            pending_q <= 1'b0;
            cnt_q <= 32'h0000_0000;
            update_req_out <= 1'b0;
        end
        else if (write_cycle_in)
        begin
            pending_q <= 1'b1;
            cnt_q <= 32'(UPDATE_CYCLES - 1);
            update_req_out <= 1'b0;
        end
        else if (pending_q && cnt_q == 32'h0000_0000)
        begin
            pending_q <= 1'b0;
            update_req_out <= 1'b1;
        end
        else
        begin
            update_req_out <= 1'b0;
            if (pending_q)
                cnt_q <= cnt_q - 32'h0000_0001;
        end
    end

endmodule // nsap_update_timer

// [testbench/nsap_access_port_checker.sv]
// Purpose: port assertions for nsap_access_port
// Assumes: control at 0x10, word read at 0x14
// Notes: bound to every instance
module nsap_chk #(
    parameter int UPDATE_CYCLES = 20
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // strap and flash control
    input wire logic flash_strap_in,
    input wire logic flash_write_cycle_in,
    input wire logic flash_write_ok_out,
    input wire logic flash_erase_ok_out,
    input wire logic auto_update_req_out,
    // memory data
    input wire logic nvm_do_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import nsap_pkg::*;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    wire rd_ctl = reg_rd_in && reg_addr_in == NSAP_CTRL_OFS;
    wire wr_ctl = reg_wr_in && reg_addr_in == NSAP_CTRL_OFS;
    logic aupd_q;
    logic [15:0] since_q;
    // ==================== enable and write-pulse tracking
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            aupd_q <= 1'b0;
        else if (wr_ctl)
            aupd_q <= reg_wdata_in[NSAP_AUPD_BIT];
    end
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            since_q <= 16'hffff;
        else if (flash_write_cycle_in)
            since_q <= 16'h0000;
        else if (since_q != 16'hffff)
            since_q <= since_q + 16'h0001;
    end
    // ==================== assertions
    chk_rdata_idle:
        assert property (!reg_rd_in |=> reg_rdata_out == 32'h0000_0000) else $error("read data without read");
    chk_rd_unmapped:
        assert property (reg_rd_in && !rd_ctl && reg_addr_in != NSAP_WORD_READ_OFS |=> reg_rdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_start_clear:
        assert property (reg_rd_in && reg_addr_in == NSAP_WORD_READ_OFS && !$past(reg_wr_in) |=> !reg_rdata_out[0])
        else $error("start bit stuck");
    chk_do_sample:
        assert property (rd_ctl && $stable(nvm_do_in) |=> reg_rdata_out[NSAP_DO_BIT] == $past(nvm_do_in, 2))
        else $error("data out bit wrong");
    chk_sector_rule:
        assert property (rd_ctl |=> !reg_rdata_out[NSAP_SEC1_BIT] || (reg_rdata_out[NSAP_PRES_BIT] && flash_strap_in))
        else $error("sector bit set wrongly");
    chk_permit_excl:
        assert property (!(flash_write_ok_out && flash_erase_ok_out)) else $error("write and erase both allowed");
    chk_permit_lock:
        assert property (wr_ctl && reg_wdata_in[5:4] == NSAP_PERMIT_RST |-> ##2 !flash_write_ok_out && !flash_erase_ok_out)
        else $error("permit 01 not blocking");
    chk_update_gate:
        assert property (auto_update_req_out |-> $past(aupd_q, 3)) else $error("update while disabled");
    chk_update_once:
        assert property (auto_update_req_out |=> !auto_update_req_out) else $error("update pulse too long");
    chk_update_delay:
        assert property (auto_update_req_out |-> since_q == UPDATE_CYCLES + 1) else $error("update delay wrong");
endmodule // nsap_chk

bind nsap_access_port nsap_chk #(.UPDATE_CYCLES(UPDATE_CYCLES)) i_chk (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .flash_strap_in(flash_strap_in), .flash_write_cycle_in(flash_write_cycle_in),
    .flash_write_ok_out(flash_write_ok_out), .flash_erase_ok_out(flash_erase_ok_out),
    .auto_update_req_out(auto_update_req_out), .nvm_do_in(nvm_do_in));

// [testbench/nsap_mem_model.sv]
// Purpose: serial memory on the far side of the port
// Assumes: opcode 0x03, 16-bit byte address, bytes streamed upward
// Notes: data out changes 1 ns after a falling serial clock
module nsap_mem_model (
    // clock
    input wire logic ref_clk_in,
    // memory pins
    input wire logic sck_in,
    input wire logic cs_in,
    input wire logic di_in,
    output logic do_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] sh = 24'h0;
    logic [15:0] ba = 16'h0;
    logic [7:0] b;
    logic op_ok = 1'b0;
    int cnt = 0;
    int k;
    initial do_out = 1'b0;
    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    always @(posedge cs_in)
    begin
        cnt = 0;
        op_ok = 1'b0;
    end
    always @(posedge sck_in)
    begin
        if (cs_in)
        begin
            sh = {sh[22:0], di_in};
            cnt = cnt + 1;
            if (cnt == 24)
            begin
                op_ok = sh[23:16] == 8'h03;
                ba = sh[15:0];
            end
        end
    end
    // undriven line: changes every cycle
    always @(posedge ref_clk_in)
    begin
        if (!cs_in || !op_ok)
            do_out <= ~do_out;
    end
    always @(negedge sck_in)
    begin
        if (cs_in && op_ok && cnt >= 24 && cnt < 40)
        begin
            k = cnt - 24;
            b = mem_byte(ba + 16'(k / 8));
            #1 do_out = b[7 - k % 8];
        end
    end
endmodule // nsap_mem_model

// [testbench/test_nvm_sw_access_port.sv]
// Purpose: self-checking bench of nsap_access_port
// Assumes: short update delay and serial half period
// Notes: random word addresses from a fixed seed
module test_nvm_sw_access_port;
    timeunit 1ns;
    timeprecision 1ps;
    import nsap_pkg::*;
    localparam int UPD = 20;
    localparam logic [3:0] CFG [3] = '{4'h6, 4'hb, 4'hf};
    localparam logic [31:0] XCTL [3] = '{32'h0000_0110, 32'h0080_0010, 32'h00c0_0110};
    localparam logic [1:0] PVAL [4] = '{NSAP_PERMIT_WRITE, NSAP_PERMIT_BAD, NSAP_PERMIT_ERASE, NSAP_PERMIT_RST};
    localparam logic [1:0] POK [4] = '{2'h2, 2'h2, 2'h1, 2'h0};
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic autoload_valid_in = 1'b0;
    nsap_autoload_t autoload_in = '0;
    logic flash_strap_in = 1'b0;
    logic flash_write_cycle_in = 1'b0;
    logic [31:0] reg_rdata_out;
    logic flash_write_ok_out, flash_erase_ok_out, auto_update_req_out;
    logic nvm_sck_out, nvm_cs_out, nvm_di_out, nvm_do_in;
    logic [31:0] seed = 32'h0000_ce18;
    logic [31:0] rd_q;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    always #10 ref_clk_in = ~ref_clk_in;
    nsap_access_port #(.UPDATE_CYCLES(UPD), .SK_HALF(2)) i_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .autoload_valid_in(autoload_valid_in), .autoload_in(autoload_in),
        .flash_strap_in(flash_strap_in), .flash_write_cycle_in(flash_write_cycle_in),
        .flash_write_ok_out(flash_write_ok_out), .flash_erase_ok_out(flash_erase_ok_out),
        .auto_update_req_out(auto_update_req_out), .nvm_sck_out(nvm_sck_out), .nvm_cs_out(nvm_cs_out),
        .nvm_di_out(nvm_di_out), .nvm_do_in(nvm_do_in));
    nsap_mem_model i_mem (.ref_clk_in(ref_clk_in), .sck_in(nvm_sck_out), .cs_in(nvm_cs_out), .di_in(nvm_di_out),
        .do_out(nvm_do_in));
    // ==================== helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] exp_word(input logic [13:0] w);
        logic [7:0] lo;
        lo = {w[6:0], 1'b0} ^ {1'b0, w[13:7]} ^ 8'h3c;
        return {lo ^ 8'h01, lo};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        rd_q = reg_rdata_out;
    endtask
    task automatic do_reset(input logic strap, input nsap_autoload_t al);
        @(posedge ref_clk_in);
        rst_b_in <= 1'b0;
        flash_strap_in <= strap;
        repeat (8) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        @(posedge ref_clk_in);
        autoload_in <= al;
        autoload_valid_in <= 1'b1;
        @(posedge ref_clk_in);
        autoload_valid_in <= 1'b0;
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_total++;
            final_report();
        end
    end
    // ==================== scenarios
    initial
    begin
        logic [31:0] r;
        logic [39:0] f;
        logic [13:0] a;
        logic [15:0] w;
        int n;
        for (int i = 0; i < 3; i++)
        begin
            do_reset(CFG[i][3], CFG[i][2:0]);
            rd(NSAP_CTRL_OFS);
            chk(rd_q & 32'hffff_fff7, XCTL[i]);
        end
        rd(NSAP_WORD_READ_OFS);
        chk(rd_q, 32'h0000_0002);
        // word reads, second start and done write while busy
        for (int i = 0; i < 8; i++)
        begin
            r = xs();
            a = (i == 0) ? 14'h3fff : (i == 1) ? 14'h000f : r[13:0];
            wr(NSAP_WORD_READ_OFS, {r[31:16], a, 2'b01});
            wr(NSAP_WORD_READ_OFS, {16'h0000, ~a, 2'b11});
            rd(NSAP_WORD_READ_OFS);
            chk({16'h0000, rd_q[15:0]}, {16'h0000, a, 2'b00});
            n = 0;
            do
            begin
                rd(NSAP_WORD_READ_OFS);
                n++;
            end
            while (rd_q[1] !== 1'b1 && n < 200);
            chk(rd_q, {exp_word(a), a, 2'b10});
            repeat (5) @(posedge ref_clk_in);
            rd(NSAP_WORD_READ_OFS);
            chk(rd_q, {exp_word(a), a, 2'b10});
        end
        rd(NSAP_CTRL_OFS);
        chk(rd_q & 32'h00c0_0100, 32'h00c0_0100);
        // direct access under grant
        wr(NSAP_CTRL_OFS, 32'h0000_0050);
        rd(NSAP_CTRL_OFS);
        chk(rd_q & 32'h0000_0080, 32'h0000_0080);
        wr(NSAP_WORD_READ_OFS, 32'h0000_0005);
        rd(NSAP_WORD_READ_OFS);
        chk({30'h0, rd_q[1:0]}, 32'h0000_0002);
        r = xs();
        a = r[13:0];
        f = {8'h03, 1'b0, a, 1'b0, 16'h0000};
        for (int i = 0; i < 40; i++)
        begin
            wr(NSAP_CTRL_OFS, 32'h0000_0052 | {29'h0, f[39 - i], 2'b00});
            if (i >= 24)
            begin
                @(posedge ref_clk_in);
                rd(NSAP_CTRL_OFS);
                w = {w[14:0], rd_q[NSAP_DO_BIT]};
            end
            wr(NSAP_CTRL_OFS, 32'h0000_0053 | {29'h0, f[39 - i], 2'b00});
        end
        wr(NSAP_CTRL_OFS, 32'h0000_0010);
        chk({16'h0000, w[7:0], w[15:8]}, {16'h0000, exp_word(a)});
        // permit field codes
        for (int i = 0; i < 4; i++)
        begin
            wr(NSAP_CTRL_OFS, {26'h0, PVAL[i], 4'h0});
            repeat (3) @(posedge ref_clk_in);
            #1;
            chk({30'h0, flash_write_ok_out, flash_erase_ok_out}, {30'h0, POK[i]});
        end
        // autonomous update on and off
        for (int en = 1; en >= 0; en--)
        begin
            wr(NSAP_CTRL_OFS, {11'h0, en[0], 20'h0_0020});
            @(posedge ref_clk_in);
            flash_write_cycle_in <= 1'b1;
            @(posedge ref_clk_in);
            flash_write_cycle_in <= 1'b0;
            w = 16'h0000;
            for (int c = 1; c <= 3 * UPD; c++)
            begin
                @(posedge ref_clk_in);
                #1;
                if (auto_update_req_out === 1'b1)
                    w = 16'(c);
            end
            chk({16'h0000, w}, (en == 1) ? 32'(UPD + 1) : 32'h0000_0000);
        end
        final_report();
    end
endmodule // test_nvm_sw_access_port
